//--- scmif_flags.sv
// pending-flag register of one serial unit
`timescale 1ns/1ns
module scmif_flags #(
   parameter logic [14:0] VALID_MASK = scmif_pkg::ALL_FLAGS
) (
   input  wire logic        sys_clk_i,
   input  wire logic        reset_n_i,
   scmif_unit_if.unit       ctl,
   input  wire logic [14:0] evt_i,
   input  wire logic [2:0]  lvl_i
);
   logic [2:0]  lvl_reg;
   logic [14:0] pend_reg;
   logic [14:0] pend_next;
   logic [14:0] set_vec;

   // ==========================================
   // status history for edge detection
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         lvl_reg <= scmif_pkg::TRIG_RST;
      end else begin
         lvl_reg <= lvl_i;
      end
   end

   // ==========================================
   // set sources
   always_comb begin
      set_vec = evt_i;
      for (int i = 0; i < scmif_pkg::NLVL; i++) begin
         if (ctl.trig[i]) begin
            set_vec[i] = lvl_i[i];
         end else begin
            set_vec[i] = lvl_i[i] & ~lvl_reg[i];
         end
      end
      if (ctl.mode == scmif_pkg::mode_off) begin
         set_vec = '0;
      end
      set_vec = set_vec & VALID_MASK;
   end

   // write-one clears; a simultaneous set wins
   always_comb begin
      pend_next = pend_reg;
      if (ctl.clr_stb) begin
         pend_next = pend_next & ~ctl.clr_mask;
      end
      pend_next = pend_next | set_vec;
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pend_reg <= scmif_pkg::PEND_RST;
      end else begin
         pend_reg <= pend_next;
      end
   end

   assign ctl.pend = pend_reg;
endmodule : scmif_flags

//--- scmif_periph_model.sv
// far-side peripheral: pulls chosen pins low, pull-up on every line
`timescale 1ns/1ns
module scmif_periph_model (
   input  wire logic [3:0] pb_out_i,
   input  wire logic [3:0] pb_oe_n_i,
   input  wire logic [3:0] pa_out_i,
   input  wire logic [3:0] pa_oe_n_i,
   input  wire logic [7:0] drv_i,
   output      logic [3:0] pb_pin_o,
   output      logic [3:0] pa_pin_o
);
   // wired-and of device and peripheral, released lines float high
   assign pb_pin_o = (pb_oe_n_i | pb_out_i) & ~drv_i[3:0];
   assign pa_pin_o = (pa_oe_n_i | pa_out_i) & ~drv_i[7:4];
endmodule : scmif_periph_model

//--- scmif_pkg.sv
// constants and types shared by the serial mode and pending-flag shell
package scmif_pkg;
   // ==========================================
   // register byte addresses
   localparam logic [31:0] PEND_ONE_ADDR = 32'h4000_A808;
   localparam logic [31:0] PEND_TWO_ADDR = 32'h4000_A80C;
   localparam logic [31:0] EN_ONE_ADDR   = 32'h4000_A848;
   localparam logic [31:0] EN_TWO_ADDR   = 32'h4000_A84C;
   localparam logic [31:0] TRIG_ONE_ADDR = 32'h4000_A854;
   localparam logic [31:0] TRIG_TWO_ADDR = 32'h4000_A858;
   localparam logic [31:0] MODE_TWO_ADDR = 32'h4000_C054;
   localparam logic [31:0] MODE_ONE_ADDR = 32'h4000_C854;
   localparam logic [31:0] CFG_TWO_ADDR  = 32'h4000_C058;
   localparam logic [31:0] CFG_ONE_ADDR  = 32'h4000_C858;
   // ==========================================
   // field layout
   localparam int unsigned NFLAG          = 15;
   localparam int unsigned NLVL           = 3;
   localparam int unsigned RX_AVAIL_BIT   = 0;
   localparam int unsigned TX_SPACE_BIT   = 1;
   localparam int unsigned TX_IDLE_BIT    = 2;
   localparam int unsigned RX_OVERRUN_BIT = 3;
   localparam int unsigned TX_UNDERRUN_BIT = 4;
   localparam int unsigned RX_DONE_BIT    = 5;
   localparam int unsigned TX_DONE_BIT    = 6;
   localparam int unsigned CMD_DONE_BIT   = 7;
   localparam int unsigned NACK_BIT       = 8;
   localparam int unsigned FRAME_ERR_BIT  = 13;
   localparam int unsigned PARITY_ERR_BIT = 14;
   localparam logic [14:0] ALL_FLAGS      = 15'h7FFF;
   localparam logic [14:0] NO_UART_FLAGS  = 15'h1FFF;
   localparam int unsigned CFG_MASTER_BIT = 0;
   localparam int unsigned CFG_FLOW_BIT   = 1;
   // ==========================================
   // reset values
   localparam logic [1:0]  MODE_RST = 2'h0;
   localparam logic [14:0] PEND_RST = 15'h0000;
   localparam logic [14:0] EN_RST   = 15'h0000;
   localparam logic [2:0]  TRIG_RST = 3'h0;
   localparam logic [1:0]  CFG_RST  = 2'h0;
   localparam logic [3:0]  OEN_RST  = 4'hF;
   // ==========================================
   // operating modes
   typedef enum logic [1:0] {
      mode_off,
      mode_uart,
      mode_spi,
      mode_twi
   } scmif_mode_t;
endpackage : scmif_pkg

//--- scmif_top.sv
// mode select, pending flags and pin roles of both serial units
// What this block does
// - two independent serial units, full duplex
// - spi master and slave per unit
// - two-wire master only, no slave
// - fifo, dma and polled paths in engines
// - mode field: off, uart, spi, two-wire
// - parity error bit 14, frame error 13
// - dma unloaded flags bits 12 to 9
// - two-wire flags bits 8 to 5
// - underrun bit 4, overrun bit 3
// - idle bit 2, space 1, rx data 0
// - unit one port b pin roles
// - unit two port a pin roles
// - cts and rts only with flow control
// - mode reads zero after reset
// - pending flags read zero after reset
// - enable bit gates each flag to irq
// - three sources edge or level triggered
`timescale 1ns/1ns
module scmif_top (
   input  wire logic        sys_clk_i,
   input  wire logic        reset_n_i,
   input  wire logic [31:0] reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output      logic [31:0] reg_rdata_o,
   output      logic        irq_one_o,
   output      logic        irq_two_o,
   input  wire logic [14:0] evt_one_i,
   input  wire logic [2:0]  lvl_one_i,
   input  wire logic [14:0] evt_two_i,
   input  wire logic [2:0]  lvl_two_i,
   output      logic [1:0]  mode_one_o,
   output      logic [1:0]  mode_two_o,
   output      logic        master_one_o,
   output      logic        master_two_o,
   output      logic        flow_one_o,
   input  wire logic        one_mosi_i,
   input  wire logic        one_miso_i,
   input  wire logic        one_sclk_i,
   input  wire logic        one_sda_low_i,
   input  wire logic        one_scl_low_i,
   input  wire logic        one_txd_i,
   input  wire logic        one_rts_low_i,
   output      logic        one_mosi_o,
   output      logic        one_miso_o,
   output      logic        one_sclk_o,
   output      logic        one_sel_low_o,
   output      logic        one_sda_o,
   output      logic        one_scl_o,
   output      logic        one_rxd_o,
   output      logic        one_cts_low_o,
   input  wire logic        two_mosi_i,
   input  wire logic        two_miso_i,
   input  wire logic        two_sclk_i,
   input  wire logic        two_sda_low_i,
   input  wire logic        two_scl_low_i,
   output      logic        two_mosi_o,
   output      logic        two_miso_o,
   output      logic        two_sclk_o,
   output      logic        two_sel_low_o,
   output      logic        two_sda_o,
   output      logic        two_scl_o,
   input  wire logic [3:0]  pb_in_i,
   output      logic [3:0]  pb_out_o,
   output      logic [3:0]  pb_oe_n_o,
   input  wire logic [3:0]  pa_in_i,
   output      logic [3:0]  pa_out_o,
   output      logic [3:0]  pa_oe_n_o
);
   scmif_unit_if u_one ();
   scmif_unit_if u_two ();

   scmif_pkg::scmif_mode_t mode_one_reg;
   scmif_pkg::scmif_mode_t mode_two_reg;
   scmif_pkg::scmif_mode_t mode_two_eff;
   logic [14:0] en_one_reg;
   logic [14:0] en_two_reg;
   logic [2:0]  trig_one_reg;
   logic [2:0]  trig_two_reg;
   logic [1:0]  cfg_one_reg;
   logic [1:0]  cfg_two_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [3:0]  pb_out_reg;
   logic [3:0]  pb_out_next;
   logic [3:0]  pb_oen_reg;
   logic [3:0]  pb_oen_next;
   logic [3:0]  pa_out_reg;
   logic [3:0]  pa_out_next;
   logic [3:0]  pa_oen_reg;
   logic [3:0]  pa_oen_next;
   logic        wr_mode_one;
   logic        wr_mode_two;

   assign wr_mode_one = reg_wr_i && reg_addr_i == scmif_pkg::MODE_ONE_ADDR;
   assign wr_mode_two = reg_wr_i && reg_addr_i == scmif_pkg::MODE_TWO_ADDR;

   // ==========================================
   // mode and configuration registers
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mode_one_reg <= scmif_pkg::scmif_mode_t'(scmif_pkg::MODE_RST);
         mode_two_reg <= scmif_pkg::scmif_mode_t'(scmif_pkg::MODE_RST);
      end else begin
         if (wr_mode_one) begin
            mode_one_reg <= scmif_pkg::scmif_mode_t'(reg_wdata_i[1:0]);
         end
         if (wr_mode_two) begin
            mode_two_reg <= scmif_pkg::scmif_mode_t'(reg_wdata_i[1:0]);
         end
      end
   end

   // unit two has no uart: that code acts as disabled
   assign mode_two_eff = (mode_two_reg == scmif_pkg::mode_uart) ?
                         scmif_pkg::mode_off : mode_two_reg;

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         en_one_reg   <= scmif_pkg::EN_RST;
         en_two_reg   <= scmif_pkg::EN_RST;
         trig_one_reg <= scmif_pkg::TRIG_RST;
         trig_two_reg <= scmif_pkg::TRIG_RST;
         cfg_one_reg  <= scmif_pkg::CFG_RST;
         cfg_two_reg  <= scmif_pkg::CFG_RST;
      end else if (reg_wr_i) begin
         unique case (reg_addr_i)
            scmif_pkg::EN_ONE_ADDR:   en_one_reg   <= reg_wdata_i[14:0];
            scmif_pkg::EN_TWO_ADDR:   en_two_reg   <= reg_wdata_i[14:0];
            scmif_pkg::TRIG_ONE_ADDR: trig_one_reg <= reg_wdata_i[2:0];
            scmif_pkg::TRIG_TWO_ADDR: trig_two_reg <= reg_wdata_i[2:0];
            scmif_pkg::CFG_ONE_ADDR:  cfg_one_reg  <= reg_wdata_i[1:0];
            scmif_pkg::CFG_TWO_ADDR:  cfg_two_reg  <= reg_wdata_i[1:0];
            default: ;
         endcase
      end
   end

   // ==========================================
   // pending-flag units
   assign u_one.mode     = mode_one_reg;
   assign u_one.trig     = trig_one_reg;
   assign u_one.clr_stb  = reg_wr_i &&
                           reg_addr_i == scmif_pkg::PEND_ONE_ADDR;
   assign u_one.clr_mask = reg_wdata_i[14:0];
   assign u_two.mode     = mode_two_eff;
   assign u_two.trig     = trig_two_reg;
   assign u_two.clr_stb  = reg_wr_i &&
                           reg_addr_i == scmif_pkg::PEND_TWO_ADDR;
   assign u_two.clr_mask = reg_wdata_i[14:0];

   // uart error flags exist on unit one only
   scmif_flags #(
      .VALID_MASK (scmif_pkg::ALL_FLAGS)
   ) u_flags_one (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .ctl       (u_one),
      .evt_i     (evt_one_i),
      .lvl_i     (lvl_one_i)
   );

   scmif_flags #(
      .VALID_MASK (scmif_pkg::NO_UART_FLAGS)
   ) u_flags_two (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .ctl       (u_two),
      .evt_i     (evt_two_i),
      .lvl_i     (lvl_two_i)
   );

   assign irq_one_o = |(u_one.pend & en_one_reg);
   assign irq_two_o = |(u_two.pend & en_two_reg);

   // ==========================================
   // register read port, data one cycle after strobe
   always_comb begin
      rdata_next = '0;
      unique case (reg_addr_i)
         scmif_pkg::PEND_ONE_ADDR: rdata_next[14:0] = u_one.pend;
         scmif_pkg::PEND_TWO_ADDR: rdata_next[14:0] = u_two.pend;
         scmif_pkg::EN_ONE_ADDR:   rdata_next[14:0] = en_one_reg;
         scmif_pkg::EN_TWO_ADDR:   rdata_next[14:0] = en_two_reg;
         scmif_pkg::TRIG_ONE_ADDR: rdata_next[2:0]  = trig_one_reg;
         scmif_pkg::TRIG_TWO_ADDR: rdata_next[2:0]  = trig_two_reg;
         scmif_pkg::MODE_ONE_ADDR: rdata_next[1:0]  = mode_one_reg;
         scmif_pkg::MODE_TWO_ADDR: rdata_next[1:0]  = mode_two_reg;
         scmif_pkg::CFG_ONE_ADDR:  rdata_next[1:0]  = cfg_one_reg;
         scmif_pkg::CFG_TWO_ADDR:  rdata_next[1:0]  = cfg_two_reg;
         default: ;
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rdata_reg <= '0;
      end else begin
         rdata_reg <= reg_rd_i ? rdata_next : '0;
      end
   end

   assign reg_rdata_o  = rdata_reg;
   assign mode_one_o   = mode_one_reg;
   assign mode_two_o   = mode_two_eff;
   assign master_one_o = cfg_one_reg[scmif_pkg::CFG_MASTER_BIT];
   assign master_two_o = cfg_two_reg[scmif_pkg::CFG_MASTER_BIT];
   assign flow_one_o   = cfg_one_reg[scmif_pkg::CFG_FLOW_BIT];

   // ==========================================
   // unit one pin drivers on port b pins 0 to 3
   always_comb begin
      pb_out_next = '0;
      pb_oen_next = scmif_pkg::OEN_RST;
      unique case (mode_one_reg)
         scmif_pkg::mode_spi: begin
            pb_oen_next[0] = 1'h0;
            if (master_one_o) begin
               pb_out_next[0] = one_mosi_i;
               pb_out_next[2] = one_sclk_i;
               pb_oen_next[2] = 1'h0;
            end else begin
               pb_out_next[0] = one_miso_i;
            end
         end
         scmif_pkg::mode_twi: begin
            pb_oen_next[0] = ~one_sda_low_i;
            pb_oen_next[1] = ~one_scl_low_i;
         end
         scmif_pkg::mode_uart: begin
            pb_out_next[0] = one_txd_i;
            pb_oen_next[0] = 1'h0;
            if (flow_one_o) begin
               pb_out_next[3] = one_rts_low_i;
               pb_oen_next[3] = 1'h0;
            end
         end
         scmif_pkg::mode_off: ;
      endcase
   end

   // ==========================================
   // unit two pin drivers on port a pins 0 to 3
   always_comb begin
      pa_out_next = '0;
      pa_oen_next = scmif_pkg::OEN_RST;
      unique case (mode_two_eff)
         scmif_pkg::mode_spi: begin
            if (master_two_o) begin
               pa_out_next[0] = two_mosi_i;
               pa_oen_next[0] = 1'h0;
               pa_out_next[2] = two_sclk_i;
               pa_oen_next[2] = 1'h0;
            end else begin
               pa_out_next[1] = two_miso_i;
               pa_oen_next[1] = 1'h0;
            end
         end
         scmif_pkg::mode_twi: begin
            pa_oen_next[1] = ~two_sda_low_i;
            pa_oen_next[2] = ~two_scl_low_i;
         end
         default: ;
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pb_out_reg <= '0;
         pb_oen_reg <= scmif_pkg::OEN_RST;
         pa_out_reg <= '0;
         pa_oen_reg <= scmif_pkg::OEN_RST;
      end else begin
         pb_out_reg <= pb_out_next;
         pb_oen_reg <= pb_oen_next;
         pa_out_reg <= pa_out_next;
         pa_oen_reg <= pa_oen_next;
      end
   end

   assign pb_out_o  = pb_out_reg;
   assign pb_oe_n_o = pb_oen_reg;
   assign pa_out_o  = pa_out_reg;
   assign pa_oe_n_o = pa_oen_reg;

   // ==========================================
   // pin inputs to the engines, idle values when unused
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         one_mosi_o    <= 1'h0;
         one_miso_o    <= 1'h0;
         one_sclk_o    <= 1'h0;
         one_sel_low_o <= 1'h1;
         one_sda_o     <= 1'h1;
         one_scl_o     <= 1'h1;
         one_rxd_o     <= 1'h1;
         one_cts_low_o <= 1'h0;
      end else begin
         one_mosi_o    <= 1'h0;
         one_miso_o    <= 1'h0;
         one_sclk_o    <= 1'h0;
         one_sel_low_o <= 1'h1;
         one_sda_o     <= 1'h1;
         one_scl_o     <= 1'h1;
         one_rxd_o     <= 1'h1;
         one_cts_low_o <= 1'h0;
         unique case (mode_one_reg)
            scmif_pkg::mode_spi: begin
               if (master_one_o) begin
                  one_miso_o    <= pb_in_i[1];
               end else begin
                  one_mosi_o    <= pb_in_i[1];
                  one_sclk_o    <= pb_in_i[2];
                  one_sel_low_o <= pb_in_i[3];
               end
            end
            scmif_pkg::mode_twi: begin
               one_sda_o <= pb_in_i[0];
               one_scl_o <= pb_in_i[1];
            end
            scmif_pkg::mode_uart: begin
               one_rxd_o <= pb_in_i[1];
               if (flow_one_o) begin
                  one_cts_low_o <= pb_in_i[2];
               end
            end
            scmif_pkg::mode_off: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         two_mosi_o    <= 1'h0;
         two_miso_o    <= 1'h0;
         two_sclk_o    <= 1'h0;
         two_sel_low_o <= 1'h1;
         two_sda_o     <= 1'h1;
         two_scl_o     <= 1'h1;
      end else begin
         two_mosi_o    <= 1'h0;
         two_miso_o    <= 1'h0;
         two_sclk_o    <= 1'h0;
         two_sel_low_o <= 1'h1;
         two_sda_o     <= 1'h1;
         two_scl_o     <= 1'h1;
         unique case (mode_two_eff)
            scmif_pkg::mode_spi: begin
               if (master_two_o) begin
                  two_miso_o    <= pa_in_i[1];
               end else begin
                  two_mosi_o    <= pa_in_i[0];
                  two_sclk_o    <= pa_in_i[2];
                  two_sel_low_o <= pa_in_i[3];
               end
            end
            scmif_pkg::mode_twi: begin
               two_sda_o <= pa_in_i[1];
               two_scl_o <= pa_in_i[2];
            end
            default: ;
         endcase
      end
   end
endmodule : scmif_top

//--- scmif_top_assertions.sv
// concurrent checks on the mode, pin role and flag ports of the shell
`timescale 1ns/1ns
module scmif_top_assertions (
   input wire logic        sys_clk_i,
   input wire logic        reset_n_i,
   input wire logic        reg_wr_i,
   input wire logic        irq_one_o,
   input wire logic [1:0]  mode_one_o,
   input wire logic [1:0]  mode_two_o,
   input wire logic        master_one_o,
   input wire logic        flow_one_o,
   input wire logic        one_sda_low_i,
   input wire logic [3:0]  pb_out_o,
   input wire logic [3:0]  pb_oe_n_o,
   input wire logic [3:0]  pa_out_o,
   input wire logic [3:0]  pa_oe_n_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   // ==========================================
   // assertions
   a_mode_reset: assert property (
      $rose(reset_n_i) |-> mode_one_o == 2'h0 && mode_two_o == 2'h0)
      else $error("mode not zero after reset");
   a_one_off: assert property (
      mode_one_o == 2'h0 [*2] |-> pb_oe_n_o == 4'hF)
      else $error("unit one drives pins while off");
   a_two_off: assert property (
      mode_two_o == 2'h0 [*2] |-> pa_oe_n_o == 4'hF)
      else $error("unit two drives pins while off");
   a_spi_master: assert property (
      (mode_one_o == 2'h2 && master_one_o) [*2] |-> pb_oe_n_o[2:0] == 3'h2)
      else $error("unit one spi master pin roles wrong");
   a_twi_drain: assert property (
      mode_one_o == 2'h3 [*2] |-> pb_out_o[1:0] == 2'h0
         && pb_oe_n_o[0] == !$past(one_sda_low_i))
      else $error("unit one two-wire data not open drain");
   a_two_twi: assert property (
      mode_two_o == 2'h3 [*2] |-> pa_out_o[2:1] == 2'h0
         && pa_oe_n_o[3] && pa_oe_n_o[0])
      else $error("unit two two-wire pin roles wrong");
   a_rts_flow: assert property (
      (mode_one_o == 2'h1 && !flow_one_o) [*2] |-> pb_oe_n_o[3:2] == 2'h3)
      else $error("flow pins used without flow control");
   a_off_irq: assert property (
      mode_one_o == 2'h0 && !irq_one_o && !reg_wr_i |=> !irq_one_o)
      else $error("new flag raised while unit one off");
endmodule : scmif_top_assertions

bind scmif_top scmif_top_assertions scmif_top_assertions_i (
   .sys_clk_i, .reset_n_i, .reg_wr_i, .irq_one_o, .mode_one_o,
   .mode_two_o, .master_one_o, .flow_one_o, .one_sda_low_i,
   .pb_out_o, .pb_oe_n_o, .pa_out_o, .pa_oe_n_o
);

//--- scmif_unit_if.sv
// carrier between the register shell and one pending-flag unit
`timescale 1ns/1ns
interface scmif_unit_if;
   scmif_pkg::scmif_mode_t mode;
   logic [2:0]             trig;
   logic                   clr_stb;
   logic [14:0]            clr_mask;
   logic [14:0]            pend;
   modport ctrl (output mode, output trig, output clr_stb,
                 output clr_mask, input pend);
   modport unit (input mode, input trig, input clr_stb,
                 input clr_mask, output pend);
endinterface : scmif_unit_if

//--- tb.sv
// self-checking bench for the serial mode and pending-flag shell
`timescale 1ns/1ns
module tb;
   logic        sys_clk_i, reset_n_i, reg_wr_i, reg_rd_i;
   logic [31:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
   logic        irq_one_o, irq_two_o, master_one_o, master_two_o;
   logic        flow_one_o;
   logic [14:0] evt_one_i, evt_two_i;
   logic [2:0]  lvl_one_i, lvl_two_i;
   logic [1:0]  mode_one_o, mode_two_o;
   logic one_mosi_i, one_miso_i, one_sclk_i, one_sda_low_i;
   logic one_scl_low_i, one_txd_i, one_rts_low_i, two_mosi_i;
   logic two_miso_i, two_sclk_i, two_sda_low_i, two_scl_low_i;
   logic one_mosi_o, one_miso_o, one_sclk_o, one_sel_low_o, one_sda_o;
   logic one_scl_o, one_rxd_o, one_cts_low_o, two_mosi_o, two_miso_o;
   logic two_sclk_o, two_sel_low_o, two_sda_o, two_scl_o;
   logic [3:0]  pb_in_i, pb_out_o, pb_oe_n_o, pa_in_i, pa_out_o, pa_oe_n_o;
   logic [7:0]  drv;
   int          num_errors, n_tests;

   scmif_top scmif_top_i (
      .sys_clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
      .reg_rd_i, .reg_rdata_o, .irq_one_o, .irq_two_o, .evt_one_i,
      .lvl_one_i, .evt_two_i, .lvl_two_i, .mode_one_o, .mode_two_o,
      .master_one_o, .master_two_o, .flow_one_o, .one_mosi_i,
      .one_miso_i, .one_sclk_i, .one_sda_low_i, .one_scl_low_i,
      .one_txd_i, .one_rts_low_i, .one_mosi_o, .one_miso_o, .one_sclk_o,
      .one_sel_low_o, .one_sda_o, .one_scl_o, .one_rxd_o, .one_cts_low_o,
      .two_mosi_i, .two_miso_i, .two_sclk_i, .two_sda_low_i,
      .two_scl_low_i, .two_mosi_o, .two_miso_o, .two_sclk_o,
      .two_sel_low_o, .two_sda_o, .two_scl_o, .pb_in_i, .pb_out_o,
      .pb_oe_n_o, .pa_in_i, .pa_out_o, .pa_oe_n_o
   );
   scmif_periph_model scmif_periph_model_i (
      .pb_out_i(pb_out_o), .pb_oe_n_i(pb_oe_n_o), .pa_out_i(pa_out_o),
      .pa_oe_n_i(pa_oe_n_o), .drv_i(drv), .pb_pin_o(pb_in_i),
      .pa_pin_o(pa_in_i)
   );

   initial begin
      sys_clk_i = 1'b0;
      forever #2 sys_clk_i = ~sys_clk_i;
   end

   // ==========================================
   // shared tasks
   task end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_sim
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask : cyc
   task wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
   endtask : wr
   task rdc(input logic [31:0] a, input logic [31:0] exp);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b0;
      #1 chk(reg_rdata_o, exp);
   endtask : rdc
   task pulse(input logic u, input logic [14:0] v);
      @(posedge sys_clk_i);
      if (u) evt_two_i <= v;
      else evt_one_i <= v;
      @(posedge sys_clk_i);
      evt_one_i <= 15'h0000;
      evt_two_i <= 15'h0000;
   endtask : pulse

   // ==========================================
   // scenarios
   task t_reset;
      rdc(scmif_pkg::MODE_ONE_ADDR, 32'h0);
      rdc(scmif_pkg::MODE_TWO_ADDR, 32'h0);
      rdc(scmif_pkg::PEND_ONE_ADDR, 32'h0);
      rdc(scmif_pkg::PEND_TWO_ADDR, 32'h0);
      wr(32'h4000_A810, 32'hFFFF_FFFF);
      rdc(32'h4000_A810, 32'h0);
      $display("test reset done");
   endtask : t_reset
   task t_flags;
      logic [31:0] m;
      for (int k = 0; k < 4; k++) begin
         wr(scmif_pkg::MODE_ONE_ADDR, k);
         rdc(scmif_pkg::MODE_ONE_ADDR, k);
         chk(mode_one_o, k);
      end
      wr(scmif_pkg::MODE_ONE_ADDR, 32'h2);
      for (int b = 3; b < 15; b++) begin
         m = 32'h1 << b;
         pulse(1'b0, m[14:0]);
         rdc(scmif_pkg::PEND_ONE_ADDR, m);
         wr(scmif_pkg::PEND_ONE_ADDR, 32'h0);
         rdc(scmif_pkg::PEND_ONE_ADDR, m);
         wr(scmif_pkg::PEND_ONE_ADDR, m);
         rdc(scmif_pkg::PEND_ONE_ADDR, 32'h0);
      end
      wr(scmif_pkg::EN_ONE_ADDR, 32'h8);
      pulse(1'b0, 15'h0018);
      #1 chk(irq_one_o, 1'b1);
      wr(scmif_pkg::PEND_ONE_ADDR, 32'h8);
      #1 chk(irq_one_o, 1'b0);
      rdc(scmif_pkg::PEND_ONE_ADDR, 32'h10);
      $display("test flags done");
   endtask : t_flags
   task t_levels;
      wr(scmif_pkg::PEND_ONE_ADDR, 32'h7FFF);
      @(posedge sys_clk_i);
      lvl_one_i <= 3'h7;
      rdc(scmif_pkg::PEND_ONE_ADDR, 32'h7);
      wr(scmif_pkg::PEND_ONE_ADDR, 32'h7);
      rdc(scmif_pkg::PEND_ONE_ADDR, 32'h0);
      wr(scmif_pkg::TRIG_ONE_ADDR, 32'h7);
      rdc(scmif_pkg::PEND_ONE_ADDR, 32'h7);
      @(posedge sys_clk_i);
      lvl_one_i <= 3'h0;
      wr(scmif_pkg::TRIG_ONE_ADDR, 32'h0);
      wr(scmif_pkg::PEND_ONE_ADDR, 32'h7);
      rdc(scmif_pkg::PEND_ONE_ADDR, 32'h0);
      $display("test levels done");
   endtask : t_levels
   task t_two;
      wr(scmif_pkg::MODE_TWO_ADDR, 32'h1);
      rdc(scmif_pkg::MODE_TWO_ADDR, 32'h1);
      chk(mode_two_o, 2'h0);
      pulse(1'b1, 15'h7FF8);
      rdc(scmif_pkg::PEND_TWO_ADDR, 32'h0);
      wr(scmif_pkg::EN_TWO_ADDR, 32'h7FFF);
      wr(scmif_pkg::MODE_TWO_ADDR, 32'h2);
      lvl_two_i <= 3'h1;
      pulse(1'b1, 15'h7FF8);
      rdc(scmif_pkg::PEND_TWO_ADDR, 32'h1FF9);
      chk(irq_two_o, 1'b1);
      wr(scmif_pkg::MODE_ONE_ADDR, 32'h0);
      wr(scmif_pkg::PEND_ONE_ADDR, 32'h7FFF);
      pulse(1'b0, 15'h7FF8);
      rdc(scmif_pkg::PEND_ONE_ADDR, 32'h0);
      $display("test unit two done");
   endtask : t_two
   task t_pins;
      wr(scmif_pkg::MODE_ONE_ADDR, 32'h2);
      one_miso_i <= 1'b1;
      drv        <= 8'h08;
      cyc(3);
      chk({pb_oe_n_o, pb_out_o[0], one_sel_low_o}, 6'h3A);
      chk({one_mosi_o, one_sclk_o}, 2'h3);
      wr(scmif_pkg::MODE_ONE_ADDR, 32'h3);
      one_sda_low_i <= 1'b1;
      drv           <= 8'h02;
      cyc(3);
      chk({pb_oe_n_o[1:0], one_sda_o, one_scl_o}, 4'h8);
      wr(scmif_pkg::MODE_ONE_ADDR, 32'h1);
      one_txd_i <= 1'b1;
      cyc(3);
      chk({pb_oe_n_o, pb_out_o[0], one_rxd_o}, 6'h3A);
      wr(scmif_pkg::MODE_ONE_ADDR, 32'h0);
      wr(scmif_pkg::CFG_ONE_ADDR, 32'h3);
      wr(scmif_pkg::MODE_ONE_ADDR, 32'h2);
      one_mosi_i <= 1'b1;
      one_sclk_i <= 1'b1;
      drv        <= 8'h00;
      cyc(3);
      chk(pb_oe_n_o, 4'hA);
      chk({pb_out_o[2], pb_out_o[0], one_miso_o}, 3'h7);
      chk(master_one_o, 1'b1);
      wr(scmif_pkg::MODE_ONE_ADDR, 32'h1);
      one_rts_low_i <= 1'b1;
      cyc(3);
      chk({pb_oe_n_o, pb_out_o[3], one_cts_low_o}, 6'h1B);
      chk(flow_one_o, 1'b1);
      wr(scmif_pkg::MODE_TWO_ADDR, 32'h3);
      two_sda_low_i <= 1'b1;
      two_scl_low_i <= 1'b1;
      cyc(3);
      chk({pa_oe_n_o, two_sda_o, two_scl_o}, 6'h24);
      wr(scmif_pkg::MODE_TWO_ADDR, 32'h2);
      two_miso_i <= 1'b1;
      drv        <= 8'h80;
      cyc(3);
      chk({pa_oe_n_o, pa_out_o[1]}, 5'h1B);
      chk({two_mosi_o, two_sclk_o, two_sel_low_o}, 3'h6);
      wr(scmif_pkg::MODE_TWO_ADDR, 32'h0);
      cyc(3);
      chk(pa_oe_n_o, 4'hF);
      wr(scmif_pkg::CFG_TWO_ADDR, 32'h1);
      wr(scmif_pkg::MODE_TWO_ADDR, 32'h2);
      two_mosi_i <= 1'b1;
      two_sclk_i <= 1'b1;
      cyc(3);
      chk({pa_oe_n_o, pa_out_o[2], pa_out_o[0], two_miso_o}, 7'h57);
      chk(master_two_o, 1'b1);
      $display("test pins done");
   endtask : t_pins

   initial begin
      {reset_n_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
      {evt_one_i, evt_two_i, lvl_one_i, lvl_two_i, drv} = '0;
      {one_mosi_i, one_miso_i, one_sclk_i, one_sda_low_i} = '0;
      {one_scl_low_i, one_txd_i, one_rts_low_i, two_mosi_i} = '0;
      {two_miso_i, two_sclk_i, two_sda_low_i, two_scl_low_i} = '0;
      repeat (4) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      t_reset;
      t_flags;
      t_levels;
      t_two;
      t_pins;
      end_sim;
   end
   initial begin
      repeat (20000) @(posedge sys_clk_i);
      num_errors++;
      end_sim;
   end
endmodule : tb
